// File: design/sfc_pkg.sv
// How it works
// - Hall plus above minus selects phase B, otherwise phase A drives.
// - Speed level 3V maps to 0% duty, 1V to 100%, linearly.
// - Level above 3V forces low-side PWM off unless floor clamp active.
// - PWM mode averages input duty: low gives 0%, high gives 100% level.
// - Effective command never below the configured floor speed.
// - Each Hall transition while running restarts the stall detect timer.
// - After ramp-up, no Hall edge within detect interval disables drive outputs.
// - Stall holds drive outputs off for the off interval, then retries ramp-up.
// - No Hall edge by end of retry ramp-up returns to off interval.
// - Hall activity at end of ramp-up enters run with stall detection.
// - Ramp-up raises current limit threshold from zero to nominal.
// - Tacho is open-drain active-low copy of Hall state.
// - Current above threshold reduces low-side PWM duty.
// - Active phase low-side output carries commutation and PWM.
// - Inactive phase low-side output held low.
// - High-side open-drain outputs carry commutation only, never PWM.
// - Detect interval 400 ms, off interval 3 s nominal.
package sfc_pkg;
    // Levels in millivolts, 8-bit duty codes
    localparam int unsigned SFC_LVL_ZERO_MV = 3000;
    localparam int unsigned SFC_LVL_FULL_MV = 1000;
    localparam int unsigned SFC_LVL_W = 12;
    localparam int unsigned SFC_DUTY_W = 8;
    localparam logic [7:0] SFC_DUTY_MAX = 8'hff;
    localparam logic [7:0] SFC_LIMIT_NOM = 8'hff;
    localparam int unsigned SFC_CLK_HZ = 25000000;
    localparam int unsigned SFC_DETECT_MS = 400;
    localparam int unsigned SFC_OFF_MS = 3000;
    localparam int unsigned SFC_RAMP_MS = 400;
    localparam int unsigned SFC_DETECT_CYC = SFC_CLK_HZ / 1000 * SFC_DETECT_MS;
    localparam int unsigned SFC_OFF_CYC = SFC_CLK_HZ / 1000 * SFC_OFF_MS;
    localparam int unsigned SFC_RAMP_CYC = SFC_CLK_HZ / 1000 * SFC_RAMP_MS;
    localparam int unsigned SFC_TMR_W = 27;
    localparam int unsigned SFC_AVG_SHIFT = 6;

    typedef enum logic [2:0]
    {
        SFC_RAMP = 3'b001,
        SFC_RUN = 3'b010,
        SFC_OFF = 3'b100
    } sfc_state_t;

    typedef struct packed
    {
        logic phase_a_low_drive;
        logic phase_b_low_drive;
        logic phase_a_high_drive_oe;
        logic phase_b_high_drive_oe;
        logic tacho_out_oe;
    } sfc_drive_t;
endpackage

// File: design/sfc_pwm_gen.sv
module sfc_pwm_gen
    import sfc_pkg::*;
#(
    parameter int unsigned W = 8
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n,
    input wire logic [W-1:0] duty_i,
    output logic pwm_o,
    output logic wrap_o
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic pwm;
    } sfc_pwm_st_t;

    sfc_pwm_st_t st_q;
    sfc_pwm_st_t st_d;

    // Full code gives steady high so 100% really is 100%
    always_comb
    begin
        st_d = st_q;
        st_d.cnt = st_q.cnt + 1'b1;
        st_d.pwm = (duty_i == {W{1'b1}}) || (st_q.cnt < duty_i);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pwm_o = st_q.pwm;
    assign wrap_o = (st_q.cnt == {W{1'b1}});
endmodule

// File: design/sfc_top.sv
module sfc_top
    import sfc_pkg::*;
#(
    parameter int unsigned DETECT_CYC = SFC_DETECT_CYC,
    parameter int unsigned OFF_CYC = SFC_OFF_CYC,
    parameter int unsigned RAMP_CYC = SFC_RAMP_CYC
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic hall_pos_above_neg_i,
    input wire logic pwm_mode_i,
    input wire logic [11:0] speed_level_in_i,
    input wire logic duty_command_in_i,
    input wire logic floor_enable_i,
    input wire logic [11:0] floor_speed_level_i,
    input wire logic over_current_i,
    output logic phase_a_low_drive_o,
    output logic phase_b_low_drive_o,
    output logic phase_a_high_drive_o,
    output logic phase_a_high_drive_oe_o,
    output logic phase_b_high_drive_o,
    output logic phase_b_high_drive_oe_o,
    output logic tacho_out_o,
    output logic tacho_out_oe_o,
    output logic [7:0] current_limit_threshold_o,
    output logic drive_enabled_o
);
    // ==========================================
    // Reset release and input synchronisers
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    typedef struct packed
    {
        logic [1:0] hall_s;
        logic [1:0] cmd_s;
        logic hall_prev;
        sfc_state_t state;
        logic [SFC_TMR_W-1:0] tmr;
        logic [15:0] avg;
        logic [7:0] limit;
        logic [7:0] backoff;
        logic moved;
        sfc_drive_t drv;
    } sfc_st_t;

    sfc_st_t st_q;
    sfc_st_t st_d;

    // ==========================================
    // Speed command path
    logic hall_now;
    logic hall_edge;
    logic [11:0] lvl_raw;
    logic [11:0] lvl_eff;
    logic floor_active;
    logic [7:0] duty_cmd;
    logic [7:0] duty_eff;
    logic pwm_raw;
    logic pwm_wrap;
    logic [23:0] span_prod;

    assign hall_now = st_q.hall_s[1];
    assign hall_edge = hall_now ^ st_q.hall_prev;

    // Top ten bits of the average settle to 0..1023: low gives zero-speed level, high full level
    always_comb
    begin
        if (pwm_mode_i)
        begin
            lvl_raw = 12'(SFC_LVL_ZERO_MV - ((SFC_LVL_ZERO_MV - SFC_LVL_FULL_MV) * st_q.avg[15:6]) / 1023);
        end
        else
        begin
            lvl_raw = speed_level_in_i;
        end
        floor_active = floor_enable_i && (lvl_raw > floor_speed_level_i);
        lvl_eff = floor_active ? floor_speed_level_i : lvl_raw;
    end

    // Linear map between the two levels
    always_comb
    begin
        span_prod = '0;
        if (lvl_eff > 12'(SFC_LVL_ZERO_MV))
        begin
            duty_cmd = 8'h00;
        end
        else if (lvl_eff <= 12'(SFC_LVL_FULL_MV))
        begin
            duty_cmd = SFC_DUTY_MAX;
        end
        else
        begin
            span_prod = 24'(12'(SFC_LVL_ZERO_MV) - lvl_eff) * 24'(SFC_DUTY_MAX);
            duty_cmd = 8'(span_prod / 24'(SFC_LVL_ZERO_MV - SFC_LVL_FULL_MV));
        end
        duty_eff = (duty_cmd > st_q.backoff) ? duty_cmd - st_q.backoff : 8'h00;
    end

    sfc_pwm_gen #(
        .W(SFC_DUTY_W)
    ) u_pwm (
        .clk_sys_i(clk_sys_i),
        .rst_n(rst_n),
        .duty_i(duty_eff),
        .pwm_o(pwm_raw),
        .wrap_o(pwm_wrap)
    );

    // ==========================================
    // Stall supervisor and drive
    logic drive_on;
    logic [SFC_TMR_W-1:0] tmr_end;

    always_comb
    begin
        unique case (st_q.state)
            SFC_RAMP: tmr_end = SFC_TMR_W'(RAMP_CYC - 1);
            SFC_RUN: tmr_end = SFC_TMR_W'(DETECT_CYC - 1);
            SFC_OFF: tmr_end = SFC_TMR_W'(OFF_CYC - 1);
            default: tmr_end = '0;
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        st_d.hall_s = {st_q.hall_s[0], hall_pos_above_neg_i};
        st_d.cmd_s = {st_q.cmd_s[0], duty_command_in_i};
        st_d.hall_prev = hall_now;
        // Leaky average stands in for the integrator capacitor
        st_d.avg = st_q.avg - (st_q.avg >> SFC_AVG_SHIFT)
            + (st_q.cmd_s[1] ? 16'(16'hffff >> SFC_AVG_SHIFT) : 16'h0000);
        st_d.tmr = st_q.tmr + 1'b1;
        if (hall_edge)
        begin
            st_d.moved = 1'b1;
        end
        unique case (st_q.state)
            SFC_RAMP:
            begin
                st_d.limit = 8'((32'(st_q.tmr) * 32'(SFC_LIMIT_NOM)) / 32'(RAMP_CYC));
                if (st_q.tmr >= tmr_end)
                begin
                    st_d.tmr = '0;
                    st_d.limit = SFC_LIMIT_NOM;
                    st_d.state = (st_q.moved || hall_edge) ? SFC_RUN : SFC_OFF;
                end
            end
            SFC_RUN:
            begin
                st_d.limit = SFC_LIMIT_NOM;
                if (hall_edge)
                begin
                    st_d.tmr = '0;
                end
                else if (st_q.tmr >= tmr_end)
                begin
                    st_d.tmr = '0;
                    st_d.state = SFC_OFF;
                end
            end
            SFC_OFF:
            begin
                st_d.limit = 8'h00;
                st_d.moved = 1'b0;
                if (st_q.tmr >= tmr_end)
                begin
                    st_d.tmr = '0;
                    st_d.state = SFC_RAMP;
                end
            end
            default:
            begin
                st_d.state = SFC_RAMP;
                st_d.tmr = '0;
            end
        endcase
        // Back off one step per PWM period while over limit, recover one step per period when clear
        if (pwm_wrap)
        begin
            if (over_current_i && st_q.backoff != 8'hff)
            begin
                st_d.backoff = st_q.backoff + 1'b1;
            end
            else if (!over_current_i && st_q.backoff != 8'h00)
            begin
                st_d.backoff = st_q.backoff - 1'b1;
            end
        end
        drive_on = (st_q.state != SFC_OFF);
        st_d.drv.phase_b_low_drive = drive_on && hall_now && pwm_raw;
        st_d.drv.phase_a_low_drive = drive_on && !hall_now && pwm_raw;
        // High side of the opposite leg pulls low, no PWM applied
        st_d.drv.phase_a_high_drive_oe = drive_on && hall_now;
        st_d.drv.phase_b_high_drive_oe = drive_on && !hall_now;
        st_d.drv.tacho_out_oe = !hall_now;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.state <= SFC_RAMP;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign phase_a_low_drive_o = st_q.drv.phase_a_low_drive;
    assign phase_b_low_drive_o = st_q.drv.phase_b_low_drive;
    assign phase_a_high_drive_o = 1'b0;
    assign phase_a_high_drive_oe_o = st_q.drv.phase_a_high_drive_oe;
    assign phase_b_high_drive_o = 1'b0;
    assign phase_b_high_drive_oe_o = st_q.drv.phase_b_high_drive_oe;
    assign tacho_out_o = 1'b0;
    assign tacho_out_oe_o = st_q.drv.tacho_out_oe;
    assign current_limit_threshold_o = st_q.limit;
    assign drive_enabled_o = (st_q.state != SFC_OFF);

    // ==========================================
    // Checks
    a_inactive_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !(phase_a_low_drive_o && phase_b_low_drive_o))
        else $error("both low-side drives high");
    a_high_no_pwm: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (phase_a_high_drive_oe_o && $past(st_q.state) == SFC_RUN && st_q.state == SFC_RUN && !$past(hall_edge))
        |-> $stable(phase_a_high_drive_oe_o))
        else $error("high side toggled without commutation");
    a_off_silent: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_OFF) ##1 (st_q.state == SFC_OFF) |->
        !phase_a_low_drive_o && !phase_b_low_drive_o && !phase_a_high_drive_oe_o && !phase_b_high_drive_oe_o)
        else $error("drive active in off interval");
    // First cycle out of reset still shows the flop reset values
    a_tacho_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $past(rst_n) |-> (tacho_out_oe_o == !$past(hall_now)))
        else $error("tacho not following hall");
    a_edge_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RUN && hall_edge) |=> (st_q.tmr == '0))
        else $error("detect timer not restarted");
    a_run_to_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RUN && !hall_edge && st_q.tmr >= tmr_end) |=> (st_q.state == SFC_OFF))
        else $error("stall not detected");
    a_off_to_ramp: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_OFF && st_q.tmr >= tmr_end) |=> (st_q.state == SFC_RAMP && st_q.tmr == '0))
        else $error("no retry after off interval");
    a_ramp_fail: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RAMP && st_q.tmr >= tmr_end && !st_q.moved && !hall_edge) |=> (st_q.state == SFC_OFF))
        else $error("failed retry not returned to off");
    a_ramp_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RAMP && st_q.tmr >= tmr_end && st_q.moved) |=> (st_q.state == SFC_RUN))
        else $error("moving motor not taken to run");
    a_limit_ramp: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RAMP && $past(st_q.state) == SFC_RAMP) |-> (st_q.limit >= $past(st_q.limit)))
        else $error("limit not rising in ramp-up");
    a_disable_lvl: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (lvl_eff > 12'(SFC_LVL_ZERO_MV)) |-> (duty_eff == 8'h00))
        else $error("duty not off above zero level");

    // ==========================================
    // Drive pattern and speed checks
    a_phase_b_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        phase_b_low_drive_o |-> $past(hall_now))
        else $error("phase b driven while hall selects phase a");
    a_phase_a_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        phase_a_low_drive_o |-> !$past(hall_now))
        else $error("phase a driven while hall selects phase b");
    a_high_commute: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        ($past(rst_n) && $past(drive_on)) |->
        ((phase_a_high_drive_oe_o == $past(hall_now)) && (phase_b_high_drive_oe_o == !$past(hall_now))))
        else $error("high side not following commutation");
    a_active_pwm: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        ($past(rst_n) && $past(drive_on)) |->
        ((phase_a_low_drive_o || phase_b_low_drive_o) == $past(pwm_raw)))
        else $error("active low side not carrying pwm");
    a_floor_clamp: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (floor_enable_i && lvl_raw > floor_speed_level_i) |-> (lvl_eff == floor_speed_level_i))
        else $error("speed level not clamped to floor");
    a_full_duty: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (lvl_eff <= 12'(SFC_LVL_FULL_MV) && st_q.backoff == 8'h00) |-> (duty_eff == SFC_DUTY_MAX))
        else $error("full level not giving full duty");
    a_pwm_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (pwm_mode_i && st_q.avg[15:6] == 10'h3ff) |-> (lvl_raw == 12'(SFC_LVL_FULL_MV)))
        else $error("steady high input not at full level");
    a_pwm_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (pwm_mode_i && st_q.avg[15:6] == 10'h000) |-> (lvl_raw == 12'(SFC_LVL_ZERO_MV)))
        else $error("steady low input not at zero level");
    a_backoff_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (pwm_wrap && over_current_i && st_q.backoff != 8'hff) |=> (st_q.backoff == $past(st_q.backoff) + 8'h01))
        else $error("backoff not raised on overcurrent");

    // ==========================================
    // Supervisor timing checks
    a_ramp_from_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RAMP && st_q.tmr == '0) |-> (current_limit_threshold_o == 8'h00))
        else $error("ramp-up not starting from zero limit");
    a_run_limit_nom: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RUN) |-> (current_limit_threshold_o == SFC_LIMIT_NOM))
        else $error("limit not nominal in run");
    a_detect_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RUN && !hall_edge && st_q.tmr < tmr_end) |=> (st_q.tmr == $past(st_q.tmr) + 1'b1))
        else $error("detect timer not counting");
    a_run_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RUN && st_q.tmr < tmr_end) |=> (st_q.state == SFC_RUN))
        else $error("run left before detect interval");
    a_ramp_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_RAMP && st_q.tmr < tmr_end) |=> (st_q.state == SFC_RAMP))
        else $error("ramp-up left early");
    a_off_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (st_q.state == SFC_OFF && st_q.tmr < tmr_end) |=> (st_q.state == SFC_OFF))
        else $error("off interval cut short");

    c_stall: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.state == SFC_RUN ##1 st_q.state == SFC_OFF);
    c_retry: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.state == SFC_OFF ##1 st_q.state == SFC_RAMP);
    c_start: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.state == SFC_RAMP ##1 st_q.state == SFC_RUN);
    c_backoff: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.backoff != 8'h00);
    c_floor: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        floor_active && duty_eff != 8'h00);
endmodule

// File: verification/sfc_fan_model.sv
// ========
// Rotor and bridge model
module sfc_fan_model
(
    input wire logic clk_sys_i,
    input wire logic spin_i,
    input wire logic phase_a_low_drive_i,
    input wire logic phase_b_low_drive_i,
    input wire logic phase_a_high_drive_oe_i,
    input wire logic phase_b_high_drive_oe_i,
    output logic hall_pos_above_neg_o,
    output int shoot_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial hall_pos_above_neg_o = 1'b0;
    initial shoot_o = 0;
    // Pole change every 20 cycles, well inside the detect window
    always @(posedge clk_sys_i)
    begin
        // Settles ahead of the bench's 2 ns sampling point
        #1;
        if (spin_i)
        begin
            cnt = cnt + 1;
            if (cnt == 20)
            begin
                cnt = 0;
                hall_pos_above_neg_o = ~hall_pos_above_neg_o;
            end
        end
        // Both switches of one leg on would short the supply
        if ((phase_a_low_drive_i && phase_a_high_drive_oe_i) || (phase_b_low_drive_i && phase_b_high_drive_oe_i))
            shoot_o = shoot_o + 1;
    end
endmodule

// File: verification/sfc_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic spin = 1'b1;
    logic pwm_mode = 1'b0;
    logic [11:0] level = 12'h3e8;
    logic duty_cmd = 1'b0;
    logic floor_en = 1'b0;
    logic [11:0] floor_lvl = 12'ha28;
    logic over_cur = 1'b0;
    logic hall, a_lo, b_lo, a_hi, a_oe, b_hi, b_oe, tacho, tacho_oe, en;
    logic [7:0] thr;
    int shoot;
    int miscompares = 0;
    int n_compared = 0;

    sfc_top #(.DETECT_CYC(50), .OFF_CYC(400), .RAMP_CYC(50)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .hall_pos_above_neg_i(hall), .pwm_mode_i(pwm_mode), .speed_level_in_i(level),
        .duty_command_in_i(duty_cmd), .floor_enable_i(floor_en), .floor_speed_level_i(floor_lvl),
        .over_current_i(over_cur), .phase_a_low_drive_o(a_lo), .phase_b_low_drive_o(b_lo),
        .phase_a_high_drive_o(a_hi), .phase_a_high_drive_oe_o(a_oe), .phase_b_high_drive_o(b_hi),
        .phase_b_high_drive_oe_o(b_oe), .tacho_out_o(tacho), .tacho_out_oe_o(tacho_oe),
        .current_limit_threshold_o(thr), .drive_enabled_o(en));
    sfc_fan_model fan (.clk_sys_i(clk_sys_i), .spin_i(spin), .phase_a_low_drive_i(a_lo),
        .phase_b_low_drive_i(b_lo), .phase_a_high_drive_oe_i(a_oe), .phase_b_high_drive_oe_i(b_oe),
        .hall_pos_above_neg_o(hall), .shoot_o(shoot));

    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // ========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    task automatic check_bit(input string name, input logic exp, input logic seen);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic check_range(input string name, input int lo, input int hi, input int seen);
        n_compared++;
        if (seen < lo || seen > hi)
        begin
            miscompares++;
            $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, seen);
        end
    endtask
    // Low-side on-time over one 256-cycle PWM period
    task automatic duty(output int hi);
        hi = 0;
        repeat (256)
        begin
            cyc(1);
            if ((a_lo | b_lo) === 1'b1)
                hi++;
        end
    endtask

    // ========
    // Scenarios
    task automatic t_reset;
        cyc(12);
        check_bit("ramp state in reset", 1'b1, en);
        check_bit("a low in reset", 1'b0, a_lo);
        rst_n_i = 1'b1;
        cyc(5);
        check_bit("ramp entered", 1'b1, en);
        check_bit("threshold early", 1'b1, thr < 8'h40);
        cyc(60);
        check_bit("threshold nominal", 1'b1, thr === 8'hff);
    endtask
    task automatic t_commute;
        logic h;
        int i;
        repeat (4)
        begin
            h = hall;
            for (i = 0; i < 40 && hall === h; i++)
                cyc(1);
            cyc(3);
            check_bit("a high oe", hall, a_oe);
            check_bit("b high oe", ~hall, b_oe);
            check_bit("inactive low", 1'b0, hall ? a_lo : b_lo);
            check_bit("active low", 1'b1, hall ? b_lo : a_lo);
            check_bit("tacho oe", ~hall, tacho_oe);
            check_bit("tacho data", 1'b0, tacho);
            check_bit("high data", 1'b0, a_hi | b_hi);
        end
    endtask
    task automatic t_speed;
        int lv[6] = '{1000, 3000, 3100, 2000, 3100, 1000};
        logic fe[6] = '{0, 0, 0, 0, 1, 1};
        int lo[6] = '{250, 0, 0, 118, 40, 250};
        int hi[6] = '{256, 0, 0, 138, 64, 256};
        int d;
        for (int i = 0; i < 6; i++)
        begin
            level = lv[i][11:0];
            floor_en = fe[i];
            duty(d);
            duty(d);
            check_range("low side duty", lo[i], hi[i], d);
        end
        floor_en = 1'b0;
        level = 12'h3e8;
    endtask
    task automatic t_current;
        int d;
        over_cur = 1'b1;
        cyc(2560);
        duty(d);
        check_range("backoff duty", 200, 250, d);
        over_cur = 1'b0;
        cyc(7680);
        duty(d);
        check_range("recovered duty", 250, 256, d);
    endtask
    task automatic t_pwm_mode;
        int d;
        pwm_mode = 1'b1;
        duty_cmd = 1'b1;
        cyc(1000);
        duty(d);
        check_range("pwm mode full", 256, 256, d);
        duty_cmd = 1'b0;
        cyc(1000);
        duty(d);
        check_range("pwm mode zero", 0, 0, d);
        pwm_mode = 1'b0;
    endtask
    task automatic t_stall;
        int n;
        spin = 1'b0;
        for (n = 0; en === 1'b1 && n < 200; n++)
            cyc(1);
        check_range("detect span", 25, 55, n);
        // Drive flops lag the state decode by one cycle
        cyc(1);
        check_bit("off drives", 1'b0, a_lo | b_lo | a_oe | b_oe);
        check_bit("off threshold", 1'b1, thr === 8'h00);
        for (n = 0; en === 1'b0 && n < 1000; n++)
            cyc(1);
        check_range("off span", 395, 405, n);
        for (n = 0; en === 1'b1 && n < 200; n++)
            cyc(1);
        check_range("retry span", 45, 55, n);
        spin = 1'b1;
        for (n = 0; en === 1'b0 && n < 500; n++)
            cyc(1);
        cyc(100);
        check_bit("run after retry", 1'b1, en);
        cyc(200);
        check_bit("kept running", 1'b1, en);
        check_range("leg shoot through", 0, 0, shoot);
    endtask

    task automatic summarize;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run is some 17700 cycles
    initial
    begin
        #2400000;
        miscompares++;
        summarize();
    end
    initial
    begin
        t_reset();
        t_commute();
        t_speed();
        t_current();
        t_pwm_mode();
        t_stall();
        summarize();
    end
endmodule
